// >>> shared/crxid_defs.svh
`ifndef CRXID_DEFS_SVH
`define CRXID_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CRXID_OFS_ID_HIGH      8'h00
`define CRXID_OFS_ID_LOW       8'h04
`define CRXID_OFS_EXT_HIGH     8'h08
`define CRXID_OFS_EXT_LOW      8'h0C
`define CRXID_OFS_LENGTH       8'h10
`define CRXID_OFS_STATUS       8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CRXID_IDL_SRR_BIT      4
`define CRXID_IDL_EXT_BIT      3
`define CRXID_IDL_UNUSED_BIT   2
`define CRXID_LEN_UNUSED_BIT   7
`define CRXID_LEN_RTR_BIT      6
`define CRXID_STAT_INV_BIT     4

// ----------------------------------------
// Masks, limits, reset values and response codes
// ----------------------------------------
`define CRXID_IDL_WMASK        8'hEB
`define CRXID_LEN_WMASK        8'h4F
`define CRXID_DLC_MAX          4'h8
`define CRXID_BYTE_RESET       8'h00
`define CRXID_RESP_OKAY        2'h0
`define CRXID_RESP_SLVERR      2'h2

`endif

// >>> shared/crxid_pkg.sv
package crxid_pkg;

  // ----------------------------------------
  // Frame handed over by the receive engine
  // ----------------------------------------
  typedef struct packed {
    logic        ext;
    logic        rtr;
    logic [28:0] id;
    logic [3:0]  dlc;
  } crxid_frame_t;

  // ----------------------------------------
  // Whole module state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  id_high;
    logic [7:0]  id_low;
    logic [7:0]  ext_high;
    logic [7:0]  ext_low;
    logic [7:0]  length;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [7:0]  wbyte;
    logic        wlane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } crxid_state_t;

endpackage

// >>> core/crxid_regs.sv
`timescale 1ns/100ps
`include "crxid_defs.svh"

module crxid_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  frame_valid,
  input  wire crxid_pkg::crxid_frame_t frame,
  input  wire logic                  buffer_remote_request_status,
  output logic [3:0]                 data_length,
  output logic                       length_invalid
);
  import crxid_pkg::*;

  crxid_state_t state_reg;
  crxid_state_t state_next;

  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        aw_now;
  logic        w_now;
  logic [7:0]  waddr;
  logic [7:0]  raddr;
  logic [7:0]  id_low_view;
  logic [7:0]  status_view;
  logic [7:0]  rbyte;
  logic        rhit;
  logic        whit;

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
  assign s_axi_wready  = !state_reg.w_got && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;

  assign aw_hs  = s_axi_awvalid && s_axi_awready;
  assign w_hs   = s_axi_wvalid && s_axi_wready;
  assign ar_hs  = s_axi_arvalid && s_axi_arready;
  assign aw_now = state_reg.aw_got || aw_hs;
  assign w_now  = state_reg.w_got || w_hs;
  assign waddr  = state_reg.aw_got ? state_reg.awaddr : 8'(s_axi_awaddr);
  assign raddr  = 8'(s_axi_araddr);

  // ----------------------------------------
  // Length decode
  // ----------------------------------------
  assign length_invalid = state_reg.length[3:0] > `CRXID_DLC_MAX;
  assign data_length    = length_invalid ? 4'h0 : state_reg.length[3:0];

  // ----------------------------------------
  // Read views
  // ----------------------------------------
  always_comb begin
    id_low_view = state_reg.id_low;
    id_low_view[`CRXID_IDL_UNUSED_BIT] = 1'b0;
    id_low_view[`CRXID_IDL_SRR_BIT] = !state_reg.id_low[`CRXID_IDL_EXT_BIT]
                                      && buffer_remote_request_status;
    status_view = {3'h0, length_invalid, data_length};
  end

  always_comb begin
    rhit  = 1'b1;
    rbyte = `CRXID_BYTE_RESET;
    case (raddr)
      `CRXID_OFS_ID_HIGH:  rbyte = state_reg.id_high;
      `CRXID_OFS_ID_LOW:   rbyte = id_low_view;
      `CRXID_OFS_EXT_HIGH: rbyte = state_reg.ext_high;
      `CRXID_OFS_EXT_LOW:  rbyte = state_reg.ext_low;
      `CRXID_OFS_LENGTH:   rbyte = state_reg.length & `CRXID_LEN_WMASK;
      `CRXID_OFS_STATUS:   rbyte = status_view;
      default:             rhit  = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    whit = 1'b1;
    case (waddr)
      `CRXID_OFS_ID_HIGH, `CRXID_OFS_ID_LOW, `CRXID_OFS_EXT_HIGH,
      `CRXID_OFS_EXT_LOW, `CRXID_OFS_LENGTH, `CRXID_OFS_STATUS: whit = 1'b1;
      default: whit = 1'b0;
    endcase
    if (aw_hs) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = 8'(s_axi_awaddr);
    end
    if (w_hs) begin
      state_next.w_got = 1'b1;
      state_next.wbyte = s_axi_wdata[7:0];
      state_next.wlane = s_axi_wstrb[0];
    end
    if (aw_now && w_now && !state_reg.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = whit ? `CRXID_RESP_OKAY : `CRXID_RESP_SLVERR;
      if (w_hs ? s_axi_wstrb[0] : state_reg.wlane) begin
        case (waddr)
          `CRXID_OFS_ID_HIGH:  state_next.id_high  = w_hs ? s_axi_wdata[7:0] : state_reg.wbyte;
          `CRXID_OFS_ID_LOW:   state_next.id_low   = (w_hs ? s_axi_wdata[7:0] : state_reg.wbyte)
                                                     & `CRXID_IDL_WMASK;
          `CRXID_OFS_EXT_HIGH: state_next.ext_high = w_hs ? s_axi_wdata[7:0] : state_reg.wbyte;
          `CRXID_OFS_EXT_LOW:  state_next.ext_low  = w_hs ? s_axi_wdata[7:0] : state_reg.wbyte;
          `CRXID_OFS_LENGTH:   state_next.length   = (w_hs ? s_axi_wdata[7:0] : state_reg.wbyte)
                                                     & `CRXID_LEN_WMASK;
          default: ;
        endcase
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (ar_hs) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = {24'h00_0000, rbyte};
      state_next.rresp  = rhit ? `CRXID_RESP_OKAY : `CRXID_RESP_SLVERR;
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    // Frame capture wins over a software write in the same cycle
    if (frame_valid) begin
      if (frame.ext) begin
        state_next.id_high  = frame.id[28:21];
        state_next.id_low   = {frame.id[20:18], 1'b0, 1'b1, 1'b0, frame.id[17:16]};
        state_next.ext_high = frame.id[15:8];
        state_next.ext_low  = frame.id[7:0];
      end else begin
        state_next.id_high  = frame.id[10:3];
        state_next.id_low   = {frame.id[2:0], 1'b0, 1'b0, 3'h0};
        state_next.ext_high = `CRXID_BYTE_RESET;
        state_next.ext_low  = `CRXID_BYTE_RESET;
      end
      state_next.length = {1'b0, frame.rtr, 2'h0, frame.dlc};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ext_sid;
    frame_valid && frame.ext |=> state_reg.id_high == $past(frame.id[28:21])
                                 && state_reg.id_low[7:5] == $past(frame.id[20:18]);
  endproperty
  a_ext_sid: assert property (p_ext_sid) else $error("extended id bits 28..18 misplaced");

  property p_ext_flag;
    frame_valid |=> state_reg.id_low[`CRXID_IDL_EXT_BIT] == $past(frame.ext);
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("extended flag wrong");

  property p_srr;
    ar_hs && raddr == `CRXID_OFS_ID_LOW
      |=> s_axi_rvalid && s_axi_rdata[`CRXID_IDL_SRR_BIT]
          == ($past(!state_reg.id_low[`CRXID_IDL_EXT_BIT]) && $past(buffer_remote_request_status));
  endproperty
  a_srr: assert property (p_srr) else $error("substitute remote bit wrong");

  property p_unused_zero;
    s_axi_rvalid && $past(ar_hs) && ($past(raddr) == `CRXID_OFS_ID_LOW
                                     || $past(raddr) == `CRXID_OFS_LENGTH)
      |-> s_axi_rdata[31:8] == 24'h00_0000
          && ($past(raddr) == `CRXID_OFS_ID_LOW ? s_axi_rdata[`CRXID_IDL_UNUSED_BIT] == 1'b0
                                                : s_axi_rdata[`CRXID_LEN_UNUSED_BIT] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unimplemented bit not zero");

  property p_ext_bytes;
    frame_valid && frame.ext |=> state_reg.ext_high == $past(frame.id[15:8])
                                 && state_reg.ext_low == $past(frame.id[7:0])
                                 && state_reg.id_low[1:0] == $past(frame.id[17:16]);
  endproperty
  a_ext_bytes: assert property (p_ext_bytes) else $error("extended bits 17..0 misplaced");

  property p_rtr;
    frame_valid |=> state_reg.length[`CRXID_LEN_RTR_BIT] == $past(frame.rtr)
                    && state_reg.length[3:0] == $past(frame.dlc);
  endproperty
  a_rtr: assert property (p_rtr) else $error("remote request bit wrong");

  property p_std_high;
    frame_valid && !frame.ext |=> state_reg.id_high == $past(frame.id[10:3]);
  endproperty
  a_std_high: assert property (p_std_high) else $error("standard high byte wrong");

  property p_dlc;
    length_invalid == (state_reg.length[3:0] > 4'h8)
      && (length_invalid || data_length == state_reg.length[3:0]);
  endproperty
  a_dlc: assert property (p_dlc) else $error("length decode wrong");

  property p_reserved;
    state_reg.length[5:4] == 2'h0 && state_reg.length[7] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved length bits set");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

endmodule

// >>> sim/crxid_frame_src.sv
`timescale 1ns/100ps

// ----------------------------------------
// Receive engine stand-in
// ----------------------------------------
module crxid_frame_src (
  input  wire logic              aclk,
  output crxid_pkg::crxid_frame_t frame,
  output logic                   frame_valid,
  output logic                   buffer_remote_request_status
);
  import crxid_pkg::*;

  initial begin
    frame_valid = 1'h0;
    frame = '0;
    buffer_remote_request_status = 1'h0;
  end

  // One-cycle capture pulse, then stale lines inverted
  task automatic send(input crxid_frame_t f, input logic s);
    buffer_remote_request_status <= s;
    frame <= f;
    frame_valid <= 1'h1;
    @(posedge aclk);
    frame_valid <= 1'h0;
    frame <= ~f;
  endtask
endmodule

// >>> sim/crxid_regs_test.sv
`timescale 1ns/100ps
`include "crxid_defs.svh"

module crxid_regs_test;
  import crxid_pkg::*;
  logic         aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]  s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]   s_axi_wstrb = 4'h0, data_length;
  logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic         s_axi_bready = 1'h0, s_axi_rready = 1'h0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic         length_invalid, frame_valid, buffer_remote_request_status;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  crxid_frame_t frame;
  int           bad_count = 0, compares = 0;

  always #50 aclk = ~aclk;

  crxid_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .frame_valid, .frame, .buffer_remote_request_status, .data_length, .length_invalid);
  crxid_frame_src i_src (.aclk, .frame, .frame_valid, .buffer_remote_request_status);

  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    input logic [3:0] st = 4'h1);
    logic ka, kw, gb;
    int n;
    gb = 1'h0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!gb && n < 40) begin
      @(negedge aclk);
      ka = s_axi_awvalid && s_axi_awready;
      kw = s_axi_wvalid && s_axi_wready;
      gb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ka) s_axi_awvalid <= 1'h0;
      if (kw) s_axi_wvalid <= 1'h0;
      n++;
    end
    chk("bvalid", 32'h0000_0001, 32'(gb));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ka, gr;
    int n;
    gr = 1'h0;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    while (!gr && n < 40) begin
      @(negedge aclk);
      ka = s_axi_arvalid && s_axi_arready;
      gr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ka) s_axi_arvalid <= 1'h0;
      n++;
    end
    chk("rvalid", 32'h0000_0001, 32'(gr));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rresp", 32'(`CRXID_RESP_OKAY), 32'(r));
    chk("rdata", {24'h00_0000, e}, d);
  endtask

  function automatic logic [39:0] expect_regs(logic e, logic r, logic [28:0] i, logic [3:0] l, logic s);
    logic [31:0] id;
    id = e ? {i[28:18], 1'h0, 1'h1, 1'h0, i[17:0]} : {i[10:0], s, 4'h0, 16'h0000};
    return {id, 1'h0, r, 2'h0, l};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_test;
    int k;
    for (k = 0; k < 6; k++) rd_chk(8'(4 * k), 8'h00);
  endtask

  task automatic frame_chk(input logic e, input logic r, input logic [28:0] i, input logic [3:0] l,
                           input logic s);
    logic [39:0] x;
    int k;
    x = expect_regs(e, r, i, l, s);
    i_src.send('{e, r, i, l}, s);
    for (k = 0; k < 5; k++) rd_chk(8'(4 * k), x[39-8*k -: 8]);
  endtask

  task automatic dlc_test;
    int l;
    logic v;
    for (l = 0; l < 16; l++) begin
      v = l > 8;
      i_src.send('{1'h0, 1'h0, 29'h0000_0123, 4'(l)}, 1'h0);
      @(negedge aclk);
      chk("length_invalid", 32'(v), 32'(length_invalid));
      chk("data_length", v ? 32'h0000_0000 : 32'(l), 32'(data_length));
      @(posedge aclk);
      rd_chk(`CRXID_OFS_STATUS, {3'h0, v, v ? 4'h0 : 4'(l)});
      rd_chk(`CRXID_OFS_LENGTH, {4'h0, 4'(l)});
    end
  endtask

  task automatic write_test;
    logic [1:0]  r;
    logic [31:0] d;
    wr(`CRXID_OFS_ID_LOW, 32'hFFFF_FFFF, r);
    chk("bresp", 32'(`CRXID_RESP_OKAY), 32'(r));
    rd_chk(`CRXID_OFS_ID_LOW, 8'hEB);
    wr(`CRXID_OFS_LENGTH, 32'hFFFF_FFFF, r);
    rd_chk(`CRXID_OFS_LENGTH, 8'h4F);
    wr(`CRXID_OFS_EXT_HIGH, 32'h0000_005A, r);
    rd_chk(`CRXID_OFS_EXT_HIGH, 8'h5A);
    wr(`CRXID_OFS_EXT_HIGH, 32'h0000_00C3, r, 4'h0);
    chk("bresp", 32'(`CRXID_RESP_OKAY), 32'(r));
    rd_chk(`CRXID_OFS_EXT_HIGH, 8'h5A);
    wr(8'h20, 32'h0000_00AA, r);
    chk("bresp", 32'(`CRXID_RESP_SLVERR), 32'(r));
    rd(8'h20, d, r);
    chk("rresp", 32'(`CRXID_RESP_SLVERR), 32'(r));
    chk("rdata", 32'h0000_0000, d);
  endtask

  task automatic test_done;
    $display("Mismatches %0d of %0d comparisons", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    s_axi_bready <= 1'h1;
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    reset_test;
    frame_chk(1'h1, 1'h1, 29'h1ABC_DEF5, 4'h5, 1'h1);
    frame_chk(1'h0, 1'h0, 29'h0000_05A3, 4'h8, 1'h1);
    frame_chk(1'h0, 1'h1, 29'h0000_02C5, 4'h0, 1'h0);
    dlc_test;
    write_test;
    test_done;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    test_done;
  end
endmodule
